//--- hdl/touch_i2c_slave.v
// two-wire slave port giving a bus master access to 16-bit registers
`timescale 1ns/1ps
`include "touch_port_regs.vh"

module touch_i2c_slave (
	input  wire        sys_clk,
	input  wire        rst,
	input  wire        scl_in,
	input  wire        sda_in,
	output reg         sda_out,
	output reg         sda_oe_n,
	output reg  [9:0]  wr_addr,
	output reg  [15:0] wr_data,
	output reg         wr_valid,
	input  wire        wr_ready,
	output reg  [9:0]  rd_addr,
	input  wire [15:0] rd_data,
	output reg         busy
);
	localparam ST_IDLE = 5'h01;
	localparam ST_ADDR = 5'h02;
	localparam ST_WRX  = 5'h04;
	localparam ST_RDX  = 5'h08;
	localparam ST_ACK  = 5'h10;

	reg        scl_m_r;
	reg        scl_s_r;
	reg        scl_d_r;
	reg        sda_m_r;
	reg        sda_s_r;
	reg        sda_d_r;
	reg [4:0]  st_r;
	reg [3:0]  bit_r;
	reg [7:0]  sh_r;
	reg [2:0]  byte_r;
	reg [9:0]  ptr_r;
	reg [7:0]  hi_r;
	reg        rd_mode_r;
	reg        rd_lo_r;
	reg        ack_drv_r;
	reg        nack_r;
	reg [7:0]  tx_r;

	wire scl_rise = scl_s_r & ~scl_d_r;
	wire scl_fall = ~scl_s_r & scl_d_r;
	wire start_ev = scl_s_r & scl_d_r & sda_d_r & ~sda_s_r;
	wire stop_ev  = scl_s_r & scl_d_r & ~sda_d_r & sda_s_r;

	wire [9:0] ptr_inc = (ptr_r == `PTR_MAX) ? ptr_r : ptr_r + 10'h001;

	// buffered write path so a busy register file stalls nothing on the wire
	reg         bi_valid_r;
	reg  [25:0] bi_data_r;
	wire        bi_ready;
	wire [25:0] bo_data;
	wire        bo_valid;

	word_skid_buf #(.W(26)) u_buf (
		.clk       (sys_clk),
		.rst       (rst),
		.in_data   (bi_data_r),
		.in_valid  (bi_valid_r),
		.in_ready  (bi_ready),
		.out_data  (bo_data),
		.out_valid (bo_valid),
		.out_ready (wr_ready | ~wr_valid)
	);

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers: first stage read only by the second
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			scl_m_r <= 1'h1;
			scl_s_r <= 1'h1;
			scl_d_r <= 1'h1;
			sda_m_r <= 1'h1;
			sda_s_r <= 1'h1;
			sda_d_r <= 1'h1;
		end else begin
			scl_m_r <= scl_in;
			scl_s_r <= scl_m_r;
			scl_d_r <= scl_s_r;
			sda_m_r <= sda_in;
			sda_s_r <= sda_m_r;
			sda_d_r <= sda_s_r;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// write output register, fed from the buffer
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			wr_valid <= 1'h0;
			wr_addr  <= `PTR_RESET;
			wr_data  <= 16'h0000;
		end else if (wr_ready | ~wr_valid) begin
			wr_valid <= bo_valid;
			if (bo_valid) begin
				wr_addr <= bo_data[25:16];
				wr_data <= bo_data[15:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// protocol engine
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			st_r       <= ST_IDLE;
			bit_r      <= 4'h0;
			sh_r       <= 8'h00;
			byte_r     <= 3'h0;
			ptr_r      <= `PTR_RESET;
			hi_r       <= 8'h00;
			rd_mode_r  <= 1'h0;
			rd_lo_r    <= 1'h0;
			ack_drv_r  <= 1'h0;
			nack_r     <= 1'h0;
			tx_r       <= 8'h00;
			sda_out    <= 1'h1;
			sda_oe_n   <= 1'h1;
			bi_valid_r <= 1'h0;
			bi_data_r  <= 26'h0000000;
			rd_addr    <= `PTR_RESET;
			busy       <= 1'h0;
		end else begin
			if (bi_valid_r & bi_ready)
				bi_valid_r <= 1'h0;
			rd_addr <= ptr_r;
			busy    <= (st_r != ST_IDLE);
			if (stop_ev) begin
				st_r     <= ST_IDLE;
				ptr_r    <= `PTR_RESET;
				sda_oe_n <= 1'h1;
				sda_out  <= 1'h1;
			end else if (start_ev) begin
				// restart keeps the pointer loaded by the address write
				st_r     <= ST_ADDR;
				bit_r    <= 4'h0;
				byte_r   <= 3'h0;
				sda_oe_n <= 1'h1;
			end else begin
				case (st_r)
				ST_IDLE: begin
					sda_oe_n <= 1'h1;
				end
				ST_ADDR, ST_WRX: begin
					if (scl_rise) begin
						sh_r  <= {sh_r[6:0], sda_s_r};
						bit_r <= bit_r + 4'h1;
					end
					if (scl_fall && bit_r == `BITS_PER_BYTE) begin
						if (st_r == ST_ADDR) begin
							if (sh_r[7:1] == `BUS_ADDR) begin
								sda_oe_n  <= 1'h0;
								sda_out   <= 1'h0;
								ack_drv_r <= 1'h1;
								rd_mode_r <= (sh_r[0] == `DIR_READ);
								rd_lo_r   <= 1'h0;
							end else begin
								st_r <= ST_IDLE;
							end
						end else begin
							sda_oe_n  <= 1'h0;
							sda_out   <= 1'h0;
							ack_drv_r <= 1'h0;
							case (byte_r)
							`ADDR_HI_BYTE:
								ptr_r[9:8] <= sh_r[1:0];
							`ADDR_LO_BYTE:
								ptr_r[7:0] <= sh_r;
							`DATA_HI_BYTE:
								hi_r <= sh_r;
							default: begin
								if (byte_r[0]) begin
									bi_data_r  <= {ptr_r, hi_r, sh_r};
									bi_valid_r <= 1'h1;
									ptr_r      <= ptr_inc;
								end else begin
									hi_r <= sh_r;
								end
							end
							endcase
							if (byte_r != `DATA_NEXT_HI)
								byte_r <= byte_r + 3'h1;
							else
								byte_r <= `DATA_HI_BYTE + 3'h1;
						end
						if (st_r == ST_WRX || sh_r[7:1] == `BUS_ADDR) begin
							st_r  <= ST_ACK;
							bit_r <= 4'h0;
						end
					end
				end
				ST_ACK: begin
					// ack held across one full clock high; at its fall released for a write, or replaced by the first data bit for a read
					if (scl_fall) begin
						bit_r <= 4'h0;
						if (rd_mode_r) begin
							st_r     <= ST_RDX;
							tx_r     <= rd_lo_r ? rd_data[7:0] : rd_data[15:8];
							sda_out  <= rd_lo_r ? rd_data[7] : rd_data[15];
							sda_oe_n <= 1'h0;
						end else begin
							st_r     <= ST_WRX;
							sda_oe_n <= 1'h1;
						end
						if (ack_drv_r)
							byte_r <= `ADDR_HI_BYTE;
					end
				end
				ST_RDX: begin
					if (scl_rise) begin
						bit_r <= bit_r + 4'h1;
						if (bit_r == `ACK_BIT_IDX)
							nack_r <= sda_s_r;
					end
					if (scl_fall) begin
						if (bit_r < `BITS_PER_BYTE) begin
							sda_out <= tx_r[7 - bit_r[2:0]];
						end else if (bit_r == `BITS_PER_BYTE) begin
							sda_oe_n <= 1'h1; // master's ack slot
						end else if (nack_r) begin
							st_r     <= ST_IDLE;
							sda_oe_n <= 1'h1;
						end else begin
							// the count restarts at zero so bit 6 follows bit 7 as in the first byte
							bit_r   <= 4'h0;
							rd_lo_r <= ~rd_lo_r;
							if (rd_lo_r) begin
								tx_r     <= rd_data[15:8];
								sda_out  <= rd_data[15];
							end else begin
								// step as the low byte is loaded: the read data lags the pointer a cycle,
								// so the next high byte must be looked up well before it is sent
								ptr_r    <= ptr_inc;
								tx_r     <= rd_data[7:0];
								sda_out  <= rd_data[7];
							end
							sda_oe_n <= 1'h0;
						end
					end
				end
				default: st_r <= ST_IDLE;
				endcase
			end
		end
	end
endmodule

//--- hdl/touch_port_regs.vh
// constants for the touch controller two-wire slave port
`ifndef TOUCH_PORT_REGS_VH
`define TOUCH_PORT_REGS_VH

`define BUS_ADDR        7'h2C
`define DIR_READ        1'h1
`define PTR_W           10
`define PTR_RESET       10'h000
`define PTR_MAX         10'h3FF
`define BITS_PER_BYTE   4'h8
`define ACK_BIT_IDX     4'h8
`define ADDR_HI_BITS    2
`define ADDR_HI_BYTE    3'h0
`define ADDR_LO_BYTE    3'h1
`define DATA_HI_BYTE    3'h2
`define DATA_LO_BYTE    3'h3
`define DATA_NEXT_HI    3'h4

`endif

//--- hdl/word_skid_buf.v
// two-entry valid/ready buffer for register words
`timescale 1ns/1ps
module word_skid_buf #(
	parameter W = 26
) (
	input  wire         clk,
	input  wire         rst,
	input  wire [W-1:0] in_data,
	input  wire         in_valid,
	output wire         in_ready,
	output wire [W-1:0] out_data,
	output wire         out_valid,
	input  wire         out_ready
);
	reg [W-1:0] mem_r [0:1];
	reg         wp_r;
	reg         rp_r;
	reg [1:0]   cnt_r;

	wire push = in_valid & in_ready;
	wire pop  = out_valid & out_ready;

	assign in_ready  = (cnt_r != 2'h2);
	assign out_valid = (cnt_r != 2'h0);
	assign out_data  = mem_r[rp_r];

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			wp_r  <= 1'h0;
			rp_r  <= 1'h0;
			cnt_r <= 2'h0;
		end else begin
			if (push)
				wp_r <= ~wp_r;
			if (pop)
				rp_r <= ~rp_r;
			cnt_r <= cnt_r + {1'h0, push} - {1'h0, pop};
		end
	end

	always @(posedge clk) begin
		if (push)
			mem_r[wp_r] <= in_data;
	end
endmodule

//--- testbench/i2c_master_model.sv
// two-wire bus master model; the bench adds the pull-up on the data wire
`timescale 1ns/1ps
module i2c_master_model (
	input  wire sys_clk,
	input  wire sda,
	output reg  scl,
	output reg  sda_m
);
	initial begin
		scl = 1'b1;
		sda_m = 1'b1;
	end
	task hc(input integer n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	// 800 ns per bit; data set two cycles into the low half
	task bit_io(input b, output s);
		sda_m = b;
		hc(2);
		scl = 1'b1;
		hc(2);
		s = sda;
		hc(2);
		scl = 1'b0;
		hc(2);
	endtask
	// also a repeated start, so the bus is kept between write and read
	task start;
		sda_m = 1'b1;
		hc(2);
		scl = 1'b1;
		hc(2);
		sda_m = 1'b0;
		hc(2);
		scl = 1'b0;
		hc(2);
	endtask
	task stop;
		sda_m = 1'b0;
		hc(2);
		scl = 1'b1;
		hc(2);
		sda_m = 1'b1;
		hc(4);
	endtask
	task xfer(input [7:0] w, input last, output [7:0] r, output ack);
		integer i;
		for (i = 7; i >= 0; i = i - 1) bit_io(w[i], r[i]);
		bit_io(last, ack);
	endtask
endmodule

//--- testbench/touch_i2c_slave_assertions.sv
// pin-level checks for the two-wire slave port
`timescale 1ns/1ps
module touch_i2c_slave_assertions (
	input wire        sys_clk,
	input wire        rst,
	input wire        scl_in,
	input wire        sda_in,
	input wire        sda_out,
	input wire        sda_oe_n,
	input wire [9:0]  wr_addr,
	input wire [15:0] wr_data,
	input wire        wr_valid,
	input wire        wr_ready,
	input wire [9:0]  rd_addr,
	input wire [15:0] rd_data,
	input wire        busy
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	a_word_holds: assert property (wr_valid && !wr_ready |=> wr_valid && $stable(wr_data))
		else $error("stalled word changed");
	a_data_steady: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe_n))
		else $error("data drive moved while clock high");
	a_ack_starts_low: assert property ($fell(sda_oe_n) |-> !scl_in)
		else $error("drive began while clock high");
	a_idle_released: assert property (!busy |-> sda_oe_n)
		else $error("line driven while idle");
	a_reset_idle: assert property ($fell(rst) |-> sda_oe_n && !busy && rd_addr == 0)
		else $error("not idle after reset");
	a_stop_clears: assert property (scl_in && $past(scl_in) && $rose(sda_in) |->
		##[1:8] rd_addr == 0 && !busy) else $error("stop left pointer set");
	a_start_busy: assert property (scl_in && $past(scl_in) && $fell(sda_in) |->
		##[1:8] busy) else $error("start not seen");
	// the pointer does not step past its maximum while the port is sending data
	a_ptr_at_max: assert property (rd_addr == 10'h3FF && !sda_oe_n |=> rd_addr == 10'h3FF)
		else $error("pointer left maximum");
	cover property (wr_valid && wr_ready);
	cover property (rd_addr == 10'h3FF && !sda_oe_n);
	cover property (!sda_oe_n && sda_out);
endmodule
////////////////////////////////////////////////////////////////
bind touch_i2c_slave touch_i2c_slave_assertions chk (.sys_clk(sys_clk), .rst(rst),
	.scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .busy(busy),
	.wr_addr(wr_addr), .wr_data(wr_data), .wr_valid(wr_valid), .wr_ready(wr_ready),
	.rd_addr(rd_addr), .rd_data(rd_data));

//--- testbench/test_touch_i2c_slave.sv
// self-checking bench for the two-wire slave port
`timescale 1ns/1ps
`define CHK(x, y) begin checks++; if ((x) !== (y)) begin fail_count++; \
	$display("wrong value at %0t: %h not %h", $time, x, y); end end
module test_touch_i2c_slave;
	reg         sys_clk = 1'b0;
	reg         rst = 1'b1;
	reg         wr_ready = 1'b0;
	wire        scl;
	wire        sda_m;
	wire        sda_out;
	wire        sda_oe_n;
	wire [9:0]  wr_addr;
	wire [15:0] wr_data;
	wire        wr_valid;
	wire [9:0]  rd_addr;
	wire        busy;
	reg  [7:0]  r;
	reg         a;
	integer     fail_count = 0;
	integer     checks = 0;
	function [15:0] val(input [9:0] x);
		val = {x, ~x[5:0]};
	endfunction
	// pulled up: low if either side pulls low
	wire        sda = sda_m & (sda_oe_n | sda_out);
	wire [15:0] rd_data = val(rd_addr);
	always #50 sys_clk = ~sys_clk;
	i2c_master_model m (.sys_clk(sys_clk), .sda(sda), .scl(scl), .sda_m(sda_m));
	touch_i2c_slave dut (.sys_clk(sys_clk), .rst(rst), .scl_in(scl), .sda_in(sda),
		.sda_out(sda_out), .sda_oe_n(sda_oe_n), .wr_addr(wr_addr), .wr_data(wr_data),
		.wr_valid(wr_valid), .wr_ready(wr_ready), .rd_addr(rd_addr), .rd_data(rd_data),
		.busy(busy));
	task wb(input [7:0] b, input e);
		m.xfer(b, 1'b1, r, a);
		`CHK(a, e)
	endtask
	task rw(input [15:0] e, input last);
		m.xfer(8'hFF, 1'b0, r, a);
		`CHK(r, e[15:8])
		m.xfer(8'hFF, last, r, a);
		`CHK(r, e[7:0])
	endtask
	task pop(input [9:0] ea, input [15:0] ed);
		integer i;
		m.hc(1);
		for (i = 0; i < 99 && wr_valid !== 1'b1; i++) m.hc(1);
		`CHK(wr_addr, ea)
		`CHK(wr_data, ed)
		wr_ready = 1'b1;
		m.hc(1);
		wr_ready = 1'b0;
	endtask
	// sink stalled for the whole frame: two words wait, the odd byte is lost
	task t_write;
		m.start;
		wb(8'h58, 1'b0);
		wb(8'hFE, 1'b0);
		wb(8'h10, 1'b0);
		wb(8'hA1, 1'b0);
		wb(8'hB2, 1'b0);
		wb(8'hC3, 1'b0);
		wb(8'hD4, 1'b0);
		wb(8'h77, 1'b0);
		m.stop;
		pop(10'h210, 16'hA1B2);
		pop(10'h211, 16'hC3D4);
		m.hc(20);
		`CHK(wr_valid, 1'b0)
	endtask
	task t_read;
		m.start;
		wb(8'h58, 1'b0);
		wb(8'h03, 1'b0);
		wb(8'hFE, 1'b0);
		m.start;
		wb(8'h59, 1'b0);
		rw(val(10'h3FE), 1'b0);
		rw(val(10'h3FF), 1'b0);
		rw(val(10'h3FF), 1'b1);
		m.stop;
	endtask
	task t_stop_ptr;
		m.start;
		wb(8'h59, 1'b0);
		rw(val(10'h000), 1'b1);
		m.stop;
		m.hc(4);
		`CHK(busy, 1'b0)
	endtask
	task t_foreign;
		m.start;
		wb(8'h5A, 1'b1);
		wb(8'h00, 1'b1);
		m.stop;
	endtask
	////////////////////////////////////////////////////////////////
	task results;
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		m.hc(4);
		rst = 1'b0;
		m.hc(4);
		t_write;
		t_read;
		t_stop_ptr;
		t_foreign;
		results;
	end
	// the four frames need well under half a millisecond
	initial begin
		#3000000;
		fail_count++;
		results;
	end
endmodule
